// ==== logic/utsp_pkg.sv ====
// package for the usb token/status/transceiver control register group
// assumes a 32-bit plain register port with byte addresses
package utsp_pkg;
    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_FRAME = 8'h28;
    localparam logic [7:0] ADDR_PID = 8'h2C;
    localparam logic [7:0] ADDR_EP = 8'h30;
    localparam logic [7:0] ADDR_EPMASK = 8'h34;
    localparam logic [7:0] ADDR_OTGMASK = 8'h38;
    localparam logic [7:0] ADDR_PWR = 8'h3C;
    localparam logic [7:0] ADDR_XCVR = 8'h40;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h44;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h48;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int FRAME_HI_LSB = 8;
    localparam int EP_VALID_BIT = 4;
    localparam int PWR_VALID_BIT = 8;
    localparam int XCVR_PD_DIS_BIT = 18;
    localparam int XCVR_RST_CAUSE_BIT = 13;
    localparam int XCVR_RES_CAUSE_BIT = 12;
    localparam int XCVR_FILT_LSB = 8;
    localparam int XCVR_SUSP_BIT = 7;
    localparam int XCVR_CONF_LSB = 4;
    localparam logic [4:0] EP_MARKER = 5'h10;
    localparam logic [3:0] PID_SOF = 4'h5;
    // interrupt status bits
    localparam int IRQ_TOKEN = 0;
    localparam int IRQ_RESET = 1;
    localparam int IRQ_RESUME = 2;
    localparam int IRQ_LINE = 3;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic [3:0] pid;
        logic [3:0] endp;
        logic [10:0] frame;
        logic crc_ok;
        logic addr_ok;
    } utsp_token_t;

    typedef struct packed {
        logic valid;
        logic [4:0] endp;
    } utsp_rx_ep_t;
endpackage : utsp_pkg

// ==== logic/utsp_top.sv ====
// usb token status and transceiver control register group
// assumes token decode results arrive synchronous to clock, one cycle valid
//
// What this block does
// R1 - writable 11-bit frame counter, written and read as one field in bits 10:0
// R2 - capture four-bit pid of last received packet, read-only, resets zero
// R3 - read-only copy of endpoint of last received token
// R4 - valid bit beside captured endpoint, clear otherwise
// R5 - sixteen-bit writable per-endpoint marking mask, resets zero
// R6 - marked endpoint presented on receive port ORed with 0x10
// R7 - pulldown-disable bit turns pulldowns off through the single pulldown_en output
// R8 - se0 auto-resume sets reset-cause bit until software writes zero
// R9 - k auto-resume sets resume-cause bit until software writes zero
// R10 - line-state change propagated after 2^field cycles, glitches filtered
// R11 - suspend control bit lets hardware handle resume, else software polls
// R12 - three-bit field drives transceiver configuration pins directly
// R13 - token good only with crc and address match; flagged
// R14 - sof token loads frame counter; software writes overwrite it
// R15 - reserved bits read zero, writes ignored
`timescale 1ns/100ps
module utsp_top
    import utsp_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire utsp_token_t token,
    input wire logic [1:0] line_state,
    input wire logic suspended,
    input wire logic [3:0] otg_flags_in,
    output utsp_rx_ep_t rx_ep,
    output logic token_decoded_flag,
    output logic [1:0] line_state_filt,
    output logic resume_req,
    output logic pulldown_en,
    output logic [2:0] transceiver_config_pins,
    output logic [31:0] otg_flags_masked,
    output logic power_signal_valid,
    output logic [7:0] power_signal_value,
    output logic irq
);
    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [10:0] frame_q;
    logic [3:0] pid_q;
    logic [3:0] ep_q;
    logic ep_valid_q;
    logic [15:0] ep_mask_q;
    logic [31:0] otg_mask_q;
    logic [7:0] pwr_data_q;
    logic pwr_valid_q;
    logic pd_dis_q;
    logic rst_cause_q;
    logic res_cause_q;
    logic [3:0] filt_q;
    logic susp_ctl_q;
    logic [2:0] conf_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [1:0] ls_filt_q;
    logic [15:0] ls_cnt_q;
    logic [1:0] ls_cand_q;
    logic good_tok;
    logic resume_se0;
    logic resume_k;
    logic ls_change;
    logic [16:0] ls_limit;
    logic wr_xcvr;

    assign good_tok = token.valid && token.crc_ok && token.addr_ok; // R13
    assign wr_xcvr = wr && addr == ADDR_XCVR;
    assign ls_limit = 17'(1) << filt_q; // R10
    assign ls_change = ls_filt_q != ls_q_next(ls_cand_q);
    assign resume_se0 = susp_ctl_q && suspended && ls_change
        && ls_cand_q == 2'h0; // R11
    assign resume_k = susp_ctl_q && suspended && ls_change
        && ls_cand_q == 2'h2; // R11

    function automatic logic [1:0] ls_q_next(input logic [1:0] c);
        ls_q_next = c;
    endfunction : ls_q_next

    // -------------------------------------------------------------
    // frame counter
    // -------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            frame_q <= 11'h000;
        else if (wr && addr == ADDR_FRAME)
            frame_q <= wdata[10:0]; // R1
        else if (good_tok && token.pid == PID_SOF)
            frame_q <= token.frame; // R14
    end

    // -------------------------------------------------------------
    // token capture
    // -------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pid_q <= 4'h0;
            ep_q <= 4'h0;
            ep_valid_q <= 1'b0;
            token_decoded_flag <= 1'b0;
            rx_ep <= '0;
        end
        else
        begin
            token_decoded_flag <= good_tok; // R13
            rx_ep.valid <= good_tok;
            if (good_tok)
            begin
                pid_q <= token.pid; // R2
                ep_q <= token.endp; // R3
                ep_valid_q <= 1'b1; // R4
                if (ep_mask_q[token.endp])
                    rx_ep.endp <= {1'b0, token.endp} | EP_MARKER; // R6
                else
                    rx_ep.endp <= {1'b0, token.endp};
            end
        end
    end

    // -------------------------------------------------------------
    // software control registers
    // -------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ep_mask_q <= 16'h0000;
            otg_mask_q <= 32'h0000_0000;
            pwr_data_q <= 8'h00;
            pwr_valid_q <= 1'b0;
            pd_dis_q <= 1'b0;
            filt_q <= 4'h0;
            susp_ctl_q <= 1'b0;
            conf_q <= 3'h0;
            irq_mask_q <= '0;
        end
        else if (wr)
        begin
            if (addr == ADDR_EPMASK)
                ep_mask_q <= wdata[15:0]; // R5
            if (addr == ADDR_OTGMASK)
                otg_mask_q <= wdata;
            if (addr == ADDR_PWR)
            begin
                pwr_data_q <= wdata[7:0];
                pwr_valid_q <= wdata[PWR_VALID_BIT];
            end
            if (wr_xcvr)
            begin
                pd_dis_q <= wdata[XCVR_PD_DIS_BIT]; // R7
                filt_q <= wdata[XCVR_FILT_LSB+:4]; // R10
                susp_ctl_q <= wdata[XCVR_SUSP_BIT]; // R11
                conf_q <= wdata[XCVR_CONF_LSB+:3]; // R12
            end
            if (addr == ADDR_IRQ_MASK)
                irq_mask_q <= wdata[IRQ_W-1:0];
        end
    end

    // -------------------------------------------------------------
    // line-state filter
    // -------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ls_filt_q <= 2'h0;
            ls_cand_q <= 2'h0;
            ls_cnt_q <= 16'h0000;
        end
        else if (line_state != ls_cand_q)
        begin
            ls_cand_q <= line_state;
            ls_cnt_q <= 16'h0001; // R10
        end
        else if (ls_cand_q != ls_filt_q)
        begin
            if ({1'b0, ls_cnt_q} >= ls_limit)
                ls_filt_q <= ls_cand_q; // R10
            else
                ls_cnt_q <= ls_cnt_q + 16'h0001;
        end
    end

    // -------------------------------------------------------------
    // resume cause flags
    // -------------------------------------------------------------
    logic ls_commit;
    assign ls_commit = line_state == ls_cand_q && ls_cand_q != ls_filt_q
        && {1'b0, ls_cnt_q} >= ls_limit;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rst_cause_q <= 1'b0;
            res_cause_q <= 1'b0;
            resume_req <= 1'b0;
        end
        else
        begin
            resume_req <= ls_commit && (resume_se0 || resume_k); // R11
            if (ls_commit && resume_se0)
                rst_cause_q <= 1'b1; // R8
            else if (wr_xcvr && !wdata[XCVR_RST_CAUSE_BIT])
                rst_cause_q <= 1'b0; // R8
            if (ls_commit && resume_k)
                res_cause_q <= 1'b1; // R9
            else if (wr_xcvr && !wdata[XCVR_RES_CAUSE_BIT])
                res_cause_q <= 1'b0; // R9
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            line_state_filt <= 2'h0;
            pulldown_en <= 1'b1;
            transceiver_config_pins <= 3'h0;
            otg_flags_masked <= 32'h0000_0000;
            power_signal_valid <= 1'b0;
            power_signal_value <= 8'h00;
        end
        else
        begin
            line_state_filt <= ls_filt_q; // R10
            pulldown_en <= !pd_dis_q; // R7
            transceiver_config_pins <= conf_q; // R12
            otg_flags_masked <= {28'h0, otg_flags_in} & otg_mask_q;
            power_signal_valid <= pwr_valid_q;
            power_signal_value <= pwr_data_q;
        end
    end

    // -------------------------------------------------------------
    // interrupts
    // -------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    assign irq_set = {ls_commit, ls_commit && resume_k,
        ls_commit && resume_se0, good_tok};

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end
        else
        begin
            if (rd && addr == ADDR_IRQ_STAT)
                irq_stat_q <= irq_set;
            else
                irq_stat_q <= irq_stat_q | irq_set;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // -------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            rdata <= RST_ZERO;
        else if (rd)
        begin
            unique case (addr)
                ADDR_FRAME: rdata <= {21'h0, frame_q}; // R1
                ADDR_PID: rdata <= {28'h0, pid_q}; // R2
                ADDR_EP: rdata <= {27'h0, ep_valid_q, ep_q}; // R4
                ADDR_EPMASK: rdata <= {16'h0, ep_mask_q};
                ADDR_OTGMASK: rdata <= otg_mask_q;
                ADDR_PWR: rdata <= {23'h0, pwr_valid_q, pwr_data_q};
                ADDR_XCVR: rdata <= {13'h0, pd_dis_q, 4'h0, rst_cause_q,
                    res_cause_q, filt_q, susp_ctl_q, conf_q, 4'h0}; // R15
                ADDR_IRQ_STAT: rdata <= {28'h0, irq_stat_q};
                ADDR_IRQ_MASK: rdata <= {28'h0, irq_mask_q};
                default: rdata <= RST_ZERO; // R15
            endcase
        end
        else
            rdata <= RST_ZERO;
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    property p_frame_load;
        @(posedge clock) disable iff (srst)
        good_tok && token.pid == PID_SOF && !wr
            |=> frame_q == $past(token.frame);
    endproperty
    a_frame_load: assert property (p_frame_load) // R14
        else $error("frame counter not loaded from sof");

    property p_ep_valid;
        @(posedge clock) disable iff (srst)
        good_tok |=> ep_valid_q && ep_q == $past(token.endp);
    endproperty
    a_ep_valid: assert property (p_ep_valid) // R3
        else $error("endpoint capture wrong");

    property p_pid;
        @(posedge clock) disable iff (srst)
        good_tok |=> pid_q == $past(token.pid);
    endproperty
    a_pid: assert property (p_pid) // R2
        else $error("pid capture wrong");

    property p_marker;
        @(posedge clock) disable iff (srst)
        good_tok && ep_mask_q[token.endp] |=> rx_ep.endp[4] && rx_ep.valid;
    endproperty
    a_marker: assert property (p_marker) // R6
        else $error("marked endpoint without marker");

    property p_bad_tok;
        @(posedge clock) disable iff (srst)
        token.valid && !token.crc_ok |=> !token_decoded_flag;
    endproperty
    a_bad_tok: assert property (p_bad_tok) // R13
        else $error("bad token flagged");

    property p_pulldown;
        @(posedge clock) disable iff (srst)
        wr_xcvr ##1 1'b1 |=> pulldown_en == !$past(wdata[XCVR_PD_DIS_BIT], 2);
    endproperty
    a_pulldown: assert property (p_pulldown) // R7
        else $error("pulldown enable wrong");

    property p_rst_cause;
        @(posedge clock) disable iff (srst)
        ls_commit && resume_se0 |=> rst_cause_q;
    endproperty
    a_rst_cause: assert property (p_rst_cause) // R8
        else $error("reset cause not set");

    property p_res_cause_hold;
        @(posedge clock) disable iff (srst)
        res_cause_q && !wr_xcvr |=> res_cause_q;
    endproperty
    a_res_cause_hold: assert property (p_res_cause_hold) // R9
        else $error("resume cause lost");

    property p_conf;
        @(posedge clock) disable iff (srst)
        wr_xcvr ##1 1'b1 |=> transceiver_config_pins == $past(wdata[6:4], 2);
    endproperty
    a_conf: assert property (p_conf) // R12
        else $error("config pins wrong");

    property p_filter;
        @(posedge clock) disable iff (srst)
        filt_q == 4'h2 && $changed(line_state) ##1 $stable(line_state)
            |-> $stable(ls_filt_q);
    endproperty
    a_filter: assert property (p_filter) // R10
        else $error("line state passed too early");
endmodule : utsp_top

// ==== test/utsp_xcvr_model.sv ====
// transceiver and host model: tokens, line state and suspend
// assumes bench requests change just after a rising clock edge
`timescale 1ns/100ps
module utsp_xcvr_model
    import utsp_pkg::*;
(
    input wire logic clock,
    input wire logic send,
    input wire utsp_token_t tok_req,
    input wire logic [1:0] ls_req,
    input wire logic susp_req,
    output utsp_token_t token = '0,
    output logic [1:0] line_state = 2'h1,
    output logic suspended = 1'b0
);
    // ---------------------------------------------------------
    // line drivers
    // ---------------------------------------------------------
    always_ff @(posedge clock)
    begin
        // idle token bus shows a changing pattern, not the last value
        token <= send ? tok_req : ~token;
        token.valid <= send;
        line_state <= ls_req;
        suspended <= susp_req;
    end
endmodule : utsp_xcvr_model

// ==== test/usb_token_status_phy_ctrl_test.sv ====
// self-checking bench for the token status and transceiver registers
// assumes utsp_top and the transceiver model on a 10 MHz clock
`timescale 1ns/100ps
module usb_token_status_phy_ctrl_test
    import utsp_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic send = 1'b0;
    logic susp_req = 1'b0;
    logic [1:0] ls_req = 2'h1;
    logic [3:0] otg_flags_in = 4'hA;
    utsp_token_t tok_req = '0;
    utsp_token_t token;
    utsp_rx_ep_t rx_ep;
    logic [31:0] rdata, otg_flags_masked, q, m_mask;
    logic [1:0] line_state, line_state_filt;
    logic suspended, token_decoded_flag, resume_req, pulldown_en, irq;
    logic power_signal_valid, m_epv, any;
    logic [2:0] transceiver_config_pins;
    logic [7:0] power_signal_value;
    logic [3:0] m_pid, m_ep;
    logic [10:0] m_frame;
    logic [31:0] r = 32'hAFF2;
    logic [7:0] ra [8] = '{ADDR_FRAME, ADDR_EPMASK, ADDR_OTGMASK, ADDR_PWR,
        ADDR_XCVR, ADDR_PID, ADDR_EP, 8'h4C};
    logic [31:0] rm [8] = '{32'h0000_07FF, 32'h0000_FFFF, 32'hFFFF_FFFF,
        32'h0000_01FF, 32'h0004_0FF0, 32'h0, 32'h0, 32'h0};
    int mismatches = 0;
    int total_checks = 0;
    int res_n = 0;
    // ---------------------------------------------------------
    // clock, design and partner
    // ---------------------------------------------------------
    always #50 clock = ~clock;
    always @(posedge clock) if (resume_req === 1'b1) res_n <= res_n + 1;
    utsp_top utsp_top_inst (.clock, .srst, .addr, .wdata, .wr, .rd, .rdata,
        .token, .line_state, .suspended, .otg_flags_in, .rx_ep,
        .token_decoded_flag, .line_state_filt, .resume_req, .pulldown_en,
        .transceiver_config_pins, .otg_flags_masked, .power_signal_valid,
        .power_signal_value, .irq);
    utsp_xcvr_model utsp_xcvr_model_inst (.clock, .send, .tok_req, .ls_req,
        .susp_req, .token, .line_state, .suspended);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] o);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 o = rdata;
    endtask : bus

    task automatic tok(input logic g, input logic [3:0] p);
        r = lfsr(r);
        @(posedge clock);
        send <= 1'b1;
        tok_req <= '{1'b1, p, r[3:0], r[14:4], g | r[20], g | !r[20]};
        @(posedge clock);
        send <= 1'b0;
        @(posedge clock);
        #1 chk(token_decoded_flag, g);
        chk(rx_ep.valid, g);
        if (g)
        begin
            m_pid = p;
            m_ep = r[3:0];
            m_epv = 1'b1;
            if (p == PID_SOF) m_frame = r[14:4];
            chk(rx_ep.endp, {m_mask[m_ep], m_ep});
        end
        bus(1'b0, ADDR_PID, 32'h0, q);
        chk(q, {28'h0, m_pid});
        bus(1'b0, ADDR_EP, 32'h0, q);
        chk(q, {27'h0, m_epv, m_ep});
        bus(1'b0, ADDR_FRAME, 32'h0, q);
        chk(q, {21'h0, m_frame});
    endtask : tok

    task automatic xcvr(input logic [31:0] d, input logic [31:0] e);
        bus(1'b1, ADDR_XCVR, d, q);
        bus(1'b0, ADDR_XCVR, 32'h0, q);
        chk(q, e);
    endtask : xcvr

    initial
    begin
        #2_000_000;
        mismatches++;
        conclude();
    end

    initial
    begin
        m_pid = 4'h0;
        m_ep = 4'h0;
        m_epv = 1'b0;
        m_frame = 11'h0;
        any = 1'b0;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        #1 chk(pulldown_en, 1'b1);
        for (int a = 8'h28; a <= 8'h4C; a += 4)
            if (a != 8'h44)
            begin
                bus(1'b0, 8'(a), 32'h0, q);
                chk(q, 32'h0);
            end
        for (int i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            bus(1'b1, ra[i], r, q);
            bus(1'b0, ra[i], 32'h0, q);
            chk(q, r & rm[i]);
            if (i == 1) m_mask = r & 32'h0000_FFFF;
            if (i == 2) chk(otg_flags_masked, {28'h0, otg_flags_in} & r);
            if (i == 3) chk({power_signal_valid, power_signal_value}, r[8:0]);
            if (i == 4) chk(pulldown_en, !r[18]);
            if (i == 4) chk(transceiver_config_pins, r[6:4]);
        end
        xcvr(32'h0000_0200, 32'h0000_0200);
        repeat (40) @(posedge clock);
        ls_req <= 2'h2;
        @(posedge clock);
        ls_req <= 2'h1;
        repeat (10) @(posedge clock);
        #1 chk(line_state_filt, 2'h1);
        ls_req <= 2'h2;
        repeat (3) @(posedge clock);
        #1 chk(line_state_filt, 2'h1);
        repeat (6) @(posedge clock);
        #1 chk(line_state_filt, 2'h2);
        xcvr(32'h0000_0280, 32'h0000_0280);
        @(posedge clock);
        ls_req <= 2'h1;
        repeat (8) @(posedge clock);
        susp_req <= 1'b1;
        ls_req <= 2'h2;
        repeat (20) @(posedge clock);
        susp_req <= 1'b0;
        xcvr(32'h0000_1280, 32'h0000_1280);
        chk(res_n, 1);
        xcvr(32'h0000_0280, 32'h0000_0280);
        @(posedge clock);
        ls_req <= 2'h0;
        susp_req <= 1'b1;
        repeat (20) @(posedge clock);
        susp_req <= 1'b0;
        ls_req <= 2'h1;
        xcvr(32'h0000_2280, 32'h0000_2280);
        chk(res_n, 2);
        xcvr(32'h0000_0200, 32'h0000_0200);
        repeat (20) @(posedge clock);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
        for (int i = 0; i < 12; i++)
        begin
            r = lfsr(r);
            any |= r[7] | r[9] | (i == 0);
            tok(r[7] | r[9] | (i == 0), (i % 3 == 0) ? PID_SOF : r[27:24]);
        end
        chk(irq, 1'b0);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
        chk(q, {31'h0, any});
        bus(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_TOKEN, q);
        tok(1'b1, 4'h1);
        chk(irq, 1'b1);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
        chk(q, 32'h1 << IRQ_TOKEN);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b0);
        bus(1'b1, ADDR_FRAME, 32'h0000_05A5, q);
        bus(1'b0, ADDR_FRAME, 32'h0, q);
        chk(q, 32'h0000_05A5);
        conclude();
    end
endmodule : usb_token_status_phy_ctrl_test
